// File: core/fpf_core.sv
/*
 Protection lock bytes, user fuse row, user signature array and completion
 polling, reached over a classic Wishbone slave (32-bit data).
 Assumes one synchronous clock; code flash itself lives outside, only its
 polling and access permissions are handled here.
*/
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
// Summary of operation
// RQ1: while programming, reads of last written byte return it with MSB inverted
// RQ2: during erase, polling returns 7FH until erase ends
// RQ3: page-write poll value is the last byte loaded, not highest address
// RQ4: two lock bytes, each all ones or all zeros
// RQ5: lock bytes return to FFH only through chip erase
// RQ6: level 2 blocks programming of every space, fuses and signature too; code still accepts lock byte writes at level 2
// RQ7: level 3 also blocks code reads; signature and fuse reads still allowed
// RQ8: FF/FF level 1, 00/FF level 2, 00/00 level 3 with debug disabled
// RQ9: programmer writes fuses before raising protection level
// RQ10: eleven fuses, each at its own byte address
// RQ11: writing 00H clears a fuse, FFH leaves it unchanged
// RQ12: fuse set back to FFH only by row erase with auto-erase write
// RQ13: all fuses default to FFH
// RQ14: clock source pair selects fast, slow crystal, external or RC
// RQ15: start-up pair selects wake-up delay code
// RQ16: programming accepted right after power-on even when disabled by fuse
// RQ17: clock and start-up fuses apply only at next power-on reset
// RQ18: reset-pin and programming-enable fuses apply when session ends
// RQ19: 128-byte signature; writes need fuse and lock permission, reads always
// RQ20: chip erase clears first signature page only when fuse enabled
// RQ21: application writes signature at address plus 128 when enabled; code's FUSE_APPPROG_EN is past the fuse row and cannot be cleared
// RQ22: power-on loads RC calibration from signature byte 0040H
// RQ23: programmer sends only 00H or FFH for fuse and lock bytes
// RQ24: last loaded byte address and value are kept for polling
module fpf_core #(
  parameter int WR_CYC  = fpf_pkg::WR_CYCLES,
  parameter int AWR_CYC = fpf_pkg::AWR_CYCLES,
  parameter int ERS_CYC = fpf_pkg::ERS_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [7:0]  rc_cal_o,
  output logic             debug_en_o
);
  localparam int CW = 24;

  typedef enum logic [1:0] {FPF_IDLE, FPF_PROG, FPF_ERASE} fpf_st_e;

  fpf_st_e               st_ff;
  logic [CW-1:0]         cnt_ff;
  logic [7:0]            lock_ff [2];
  logic [7:0]            fuse_ff [fpf_pkg::NUM_FUSES];
  logic [7:0]            sig_ff  [fpf_pkg::SIG_BYTES];
  logic [7:0]            op_ff;
  logic [15:0]           addr_ff;
  logic [7:0]            data_ff;
  logic [15:0]           poll_addr_ff;
  logic [7:0]            poll_data_ff;
  logic                  poll_space_code_ff;
  logic [7:0]            rdata_ff;
  logic                  rd_ok_ff;
  fpf_pkg::fpf_clk_e     clk_sel_ff;
  logic [1:0]            startup_sel_ff;
  logic                  rst_pin_en_ff;
  logic                  serprog_en_ff;
  logic                  por_window_ff;
  logic                  appprog_en_ff;

  logic                  req;
  logic [1:0]            level;
  logic                  prog_ok;
  logic                  serprog_ok;
  fpf_pkg::fpf_op_e      op;
  fpf_pkg::fpf_space_e   sp;
  logic [6:0]            sidx;
  logic [3:0]            fidx;
  logic                  fuse_valid;
  logic [7:0]            nxt_rdata;
  logic                  nxt_rd_ok;

  assign req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign op   = fpf_pkg::fpf_op_e'(wb_dat_i[3:0]);
  assign sp   = fpf_pkg::fpf_space_e'(wb_dat_i[5:4]);
  assign sidx = addr_ff[6:0];
  assign fidx = addr_ff[3:0];
  assign fuse_valid = (addr_ff[15:4] == 12'h000) && (fidx < 4'(fpf_pkg::NUM_FUSES));

  // level from lock bytes: index 0 gates level 2, index 1 level 3
  assign level = (lock_ff[0] == fpf_pkg::BYTE_ONES) ? 2'd1 :       // RQ8
                 (lock_ff[1] == fpf_pkg::BYTE_ONES) ? 2'd2 : 2'd3; // RQ8
  assign prog_ok = (level == 2'd1);                                // RQ6
  assign serprog_ok = serprog_en_ff || por_window_ff;              // RQ16

  // command register write launches an operation
  logic cmd_go;
  assign cmd_go = req && wb_we_i && (wb_adr_i == fpf_pkg::REG_CMD) && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_ff <= 16'h0000;
      data_ff <= 8'h00;
    end else if (req && wb_we_i) begin
      if (wb_adr_i == fpf_pkg::REG_ADDR && wb_sel_i[0]) begin
        addr_ff[7:0] <= wb_dat_i[7:0];
      end
      if (wb_adr_i == fpf_pkg::REG_ADDR && wb_sel_i[1]) begin
        addr_ff[15:8] <= wb_dat_i[15:8];
      end
      if (wb_adr_i == fpf_pkg::REG_DATA && wb_sel_i[0]) begin
        data_ff <= wb_dat_i[7:0];
      end
    end
  end

  // busy timer; while busy only read, power-on and session-end commands still act
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff  <= FPF_IDLE;
      cnt_ff <= '0;
    end else begin
      case (st_ff)
        FPF_IDLE: begin
          if (cmd_go && serprog_ok && prog_ok && op == fpf_pkg::FPF_OP_WRITE) begin
            st_ff  <= FPF_PROG;
            cnt_ff <= CW'(WR_CYC - 1);
          end else if (cmd_go && serprog_ok && prog_ok && op == fpf_pkg::FPF_OP_WRITE_AE) begin
            st_ff  <= FPF_PROG;
            cnt_ff <= CW'(AWR_CYC - 1);
          end else if (cmd_go && serprog_ok && op == fpf_pkg::FPF_OP_CHIP_ERASE) begin
            st_ff  <= FPF_ERASE;
            cnt_ff <= CW'(ERS_CYC - 1);
          end
        end
        default: begin
          if (cnt_ff == '0) begin
            st_ff <= FPF_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
      endcase
    end
  end

  // last loaded byte is the poll reference
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      poll_addr_ff       <= 16'h0000;
      poll_data_ff       <= 8'h00;
      poll_space_code_ff <= 1'b0;
    end else if (cmd_go && st_ff == FPF_IDLE && op == fpf_pkg::FPF_OP_LOAD) begin
      poll_addr_ff       <= addr_ff;  // RQ24
      poll_data_ff       <= data_ff;  // RQ3
      poll_space_code_ff <= (sp == fpf_pkg::FPF_SP_CODE);
    end
  end

  // lock bytes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_ff[0] <= fpf_pkg::BYTE_ONES;
      lock_ff[1] <= fpf_pkg::BYTE_ONES;
    end else if (cmd_go && st_ff == FPF_IDLE && serprog_ok) begin
      if (op == fpf_pkg::FPF_OP_CHIP_ERASE) begin
        lock_ff[0] <= fpf_pkg::BYTE_ONES;  // RQ5
        lock_ff[1] <= fpf_pkg::BYTE_ONES;  // RQ5
      end else if ((op == fpf_pkg::FPF_OP_WRITE || op == fpf_pkg::FPF_OP_WRITE_AE) && sp == fpf_pkg::FPF_SP_LOCK
                   && addr_ff[15:1] == 15'h0000 && data_ff == fpf_pkg::BYTE_ZERO) begin
        lock_ff[addr_ff[0]] <= fpf_pkg::BYTE_ZERO;  // RQ4
      end
    end
  end

  // fuse row: clear on 00H, keep on FFH, auto-erase sets row first
  genvar gi;
  generate
    for (gi = 0; gi < fpf_pkg::NUM_FUSES; gi++) begin : g_fuse
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          fuse_ff[gi] <= fpf_pkg::BYTE_ONES;  // RQ13
        end else if (cmd_go && st_ff == FPF_IDLE && serprog_ok && prog_ok && sp == fpf_pkg::FPF_SP_FUSE) begin
          if (fuse_valid && fidx == 4'(gi) && data_ff == fpf_pkg::BYTE_ZERO
              && (op == fpf_pkg::FPF_OP_WRITE || op == fpf_pkg::FPF_OP_WRITE_AE)) begin
            fuse_ff[gi] <= fpf_pkg::BYTE_ZERO;  // RQ10 RQ11
          end else if (op == fpf_pkg::FPF_OP_WRITE_AE) begin
            fuse_ff[gi] <= fpf_pkg::BYTE_ONES;  // RQ12
          end
        end
      end
    end
  endgenerate

  // signature array; no reset, nonvolatile contents
  always_ff @(posedge clk_i) begin
    if (cmd_go && st_ff == FPF_IDLE) begin
      if (op == fpf_pkg::FPF_OP_APP_WRITE && appprog_en_ff && addr_ff[15:7] == 9'h001) begin
        sig_ff[sidx] <= data_ff;  // RQ21
      end else if (serprog_ok && prog_ok && fuse_ff[fpf_pkg::FUSE_SIG_PROG] == fpf_pkg::BYTE_ZERO) begin
        if ((op == fpf_pkg::FPF_OP_WRITE || op == fpf_pkg::FPF_OP_WRITE_AE)
            && sp == fpf_pkg::FPF_SP_SIG && addr_ff[15:7] == 9'h000) begin
          sig_ff[sidx] <= data_ff;  // RQ19
        end
      end
      if (op == fpf_pkg::FPF_OP_CHIP_ERASE && serprog_ok && fuse_ff[fpf_pkg::FUSE_SIG_PROG] == fpf_pkg::BYTE_ZERO) begin
        for (int i = 0; i < fpf_pkg::SIG_PAGE; i++) begin
          sig_ff[i] <= fpf_pkg::BYTE_ONES;  // RQ20
        end
      end
    end
  end

  // power-on applies clock/start-up fuses and calibration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_sel_ff <= fpf_pkg::FPF_CLK_RC;
      startup_sel_ff <= 2'b11;
      rc_cal_o   <= 8'h00;
      debug_en_o <= 1'b0;
    end else begin
      debug_en_o <= (level != 2'd3) && (fuse_ff[fpf_pkg::FUSE_DEBUG_EN] == fpf_pkg::BYTE_ZERO);  // RQ8
      if (cmd_go && op == fpf_pkg::FPF_OP_POR) begin
        clk_sel_ff <= fpf_pkg::fpf_clk_e'({fuse_ff[fpf_pkg::FUSE_CS0][0], fuse_ff[fpf_pkg::FUSE_CS1][0]});  // RQ14 RQ17
        startup_sel_ff <= {fuse_ff[fpf_pkg::FUSE_STARTUP0][0], fuse_ff[fpf_pkg::FUSE_STARTUP1][0]};  // RQ15 RQ17
        rc_cal_o   <= sig_ff[fpf_pkg::RC_CAL_ADDR[6:0]];  // RQ22
      end
    end
  end

  // session-end fuses; power-on opens the programming window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_pin_en_ff <= 1'b1;
      serprog_en_ff <= 1'b1;
      appprog_en_ff <= 1'b0;
      por_window_ff <= 1'b1;
    end else if (cmd_go) begin
      if (op == fpf_pkg::FPF_OP_SESSION_END) begin
        rst_pin_en_ff <= fuse_ff[fpf_pkg::FUSE_RST_EN] == fpf_pkg::BYTE_ONES;  // RQ18
        serprog_en_ff <= fuse_ff[fpf_pkg::FUSE_SERPROG_EN] == fpf_pkg::BYTE_ONES;  // RQ18
        appprog_en_ff <= fuse_ff[fpf_pkg::FUSE_APPPROG_EN] == fpf_pkg::BYTE_ZERO;
        por_window_ff <= 1'b0;
      end else if (op == fpf_pkg::FPF_OP_POR) begin
        por_window_ff <= 1'b1;  // RQ16
        appprog_en_ff <= fuse_ff[fpf_pkg::FUSE_APPPROG_EN] == fpf_pkg::BYTE_ZERO;
      end
    end
  end

  // read path, one byte per read command
  always_comb begin
    nxt_rdata = fpf_pkg::BYTE_ONES;
    nxt_rd_ok = 1'b1;
    case (sp)
      fpf_pkg::FPF_SP_FUSE: nxt_rdata = fuse_valid ? fuse_ff[fidx] : fpf_pkg::BYTE_ONES;
      fpf_pkg::FPF_SP_LOCK: nxt_rdata = (addr_ff[15:1] == 15'h0000) ? lock_ff[addr_ff[0]] : fpf_pkg::BYTE_ONES;
      fpf_pkg::FPF_SP_SIG:  nxt_rdata = sig_ff[sidx];  // RQ19
      default: begin
        nxt_rd_ok = (level != 2'd3);  // RQ7
        nxt_rdata = fpf_pkg::BYTE_ONES;
      end
    endcase
    if (st_ff == FPF_ERASE) begin
      nxt_rdata = fpf_pkg::POLL_ERASE;  // RQ2
    end else if (st_ff == FPF_PROG && addr_ff == poll_addr_ff
                 && (sp == fpf_pkg::FPF_SP_CODE) == poll_space_code_ff) begin
      nxt_rdata = {~poll_data_ff[7], poll_data_ff[6:0]};  // RQ1
      nxt_rd_ok = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= 8'h00;
      rd_ok_ff <= 1'b0;
    end else if (cmd_go && op == fpf_pkg::FPF_OP_READ) begin
      rdata_ff <= nxt_rd_ok ? nxt_rdata : 8'h00;
      rd_ok_ff <= nxt_rd_ok;
    end
  end

  fpf_pkg::fpf_status_s status;
  assign status = '{prot_level: level, clk_sel: clk_sel_ff, startup_sel: startup_sel_ff, reset_pin_en: rst_pin_en_ff,
                    serprog_en: serprog_ok, debug_en: debug_en_o, busy: (st_ff != FPF_IDLE)};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      if (wb_adr_i == fpf_pkg::REG_ADDR) begin
        wb_dat_o <= {16'h0000, addr_ff};
      end else if (wb_adr_i == fpf_pkg::REG_DATA) begin
        wb_dat_o <= {24'h000000, data_ff};
      end else if (wb_adr_i == fpf_pkg::REG_STATUS) begin
        wb_dat_o <= {22'h000000, status};
      end else if (wb_adr_i == fpf_pkg::REG_RDATA) begin
        wb_dat_o <= {23'h000000, rd_ok_ff, rdata_ff};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end
endmodule : fpf_core

// File: core/fpf_pkg.sv
/*
 Package for the flash protection, fuse and completion-poll block:
 space codes, operation codes, fuse addresses, Wishbone register offsets and
 timing counts. Assumes a 125 MHz system clock.
*/
package fpf_pkg;
  localparam int          CLK_MHZ          = 125;
  // programming cycle times in microseconds, derived counts are time times CLK_MHZ
  localparam int          WR_TIME_US       = 2500;
  localparam int          AWR_TIME_US      = 5000;
  localparam int          ERS_TIME_US      = 7500;
  localparam int          WR_CYCLES        = WR_TIME_US * CLK_MHZ;
  localparam int          AWR_CYCLES       = AWR_TIME_US * CLK_MHZ;
  localparam int          ERS_CYCLES       = ERS_TIME_US * CLK_MHZ;

  localparam int          NUM_FUSES        = 11;
  localparam int          SIG_BYTES        = 128;
  localparam int          SIG_PAGE         = 64;
  localparam logic [7:0]  BYTE_ONES        = 8'hFF;
  localparam logic [7:0]  BYTE_ZERO        = 8'h00;
  localparam logic [7:0]  POLL_ERASE       = 8'h7F;
  localparam logic [7:0]  APP_SIG_BASE     = 8'h80;
  localparam logic [7:0]  RC_CAL_ADDR      = 8'h40;

  // fuse addresses inside the fuse row, except FUSE_APPPROG_EN past the last of the NUM_FUSES entries
  localparam logic [3:0]  FUSE_CS0         = 4'h0;
  localparam logic [3:0]  FUSE_CS1         = 4'h1;
  localparam logic [3:0]  FUSE_STARTUP0    = 4'h2;
  localparam logic [3:0]  FUSE_STARTUP1    = 4'h3;
  localparam logic [3:0]  FUSE_RST_EN      = 4'h4;
  localparam logic [3:0]  FUSE_BROWNOUT_EN = 4'h5;
  localparam logic [3:0]  FUSE_DEBUG_EN    = 4'h6;
  localparam logic [3:0]  FUSE_SERPROG_EN  = 4'h7;
  localparam logic [3:0]  FUSE_SIG_PROG    = 4'h8;
  localparam logic [3:0]  FUSE_APPPROG_EN  = 4'hB;

  // Wishbone register offsets (byte addresses, word aligned)
  localparam logic [7:0]  REG_CMD          = 8'h00;
  localparam logic [7:0]  REG_ADDR         = 8'h04;
  localparam logic [7:0]  REG_DATA         = 8'h08;
  localparam logic [7:0]  REG_STATUS       = 8'h0C;
  localparam logic [7:0]  REG_CONFIG       = 8'h10;
  localparam logic [7:0]  REG_RDATA        = 8'h14;

  typedef enum logic [3:0] {
    FPF_OP_NONE, FPF_OP_LOAD, FPF_OP_WRITE, FPF_OP_WRITE_AE, FPF_OP_READ,
    FPF_OP_CHIP_ERASE, FPF_OP_POR, FPF_OP_SESSION_END, FPF_OP_APP_WRITE
  } fpf_op_e;

  typedef enum logic [1:0] {
    FPF_SP_CODE, FPF_SP_FUSE, FPF_SP_LOCK, FPF_SP_SIG
  } fpf_space_e;

  typedef enum logic [1:0] {
    FPF_CLK_FAST_CRYSTAL, FPF_CLK_SLOW_CRYSTAL, FPF_CLK_EXT, FPF_CLK_RC
  } fpf_clk_e;

  typedef struct packed {
    logic [1:0] prot_level;
    fpf_clk_e   clk_sel;
    logic [1:0] startup_sel;
    logic       reset_pin_en;
    logic       serprog_en;
    logic       debug_en;
    logic       busy;
  } fpf_status_s;
endpackage : fpf_pkg

// File: test/fpf_core_asserts.sv
/*
 Checker for the protection and fuse block: bus timing and output relations.
 Assumes it sees only the ports of fpf_core, one clock, synchronous reset.
*/
`timescale 1ns/1ns
module fpf_core_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [7:0]  rc_cal_o,
  input wire logic        debug_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       req;
  logic [2:0] since_cmd_ff;
  assign req = wb_cyc_i && wb_stb_i;
  // short window after a command write, for the calibration load
  always_ff @(posedge clk_i) begin
    if (rst_i || (req && wb_we_i && wb_adr_i == fpf_pkg::REG_CMD)) since_cmd_ff <= 3'h0;
    else if (since_cmd_ff != 3'h7) since_cmd_ff <= since_cmd_ff + 3'h1;
  end
  a_ack_next: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  a_idle_quiet: assert property (!req [*2] |-> !wb_ack_o)
    else $error("ack while bus idle");
  a_rdata_ack: assert property ($changed(wb_dat_o) |-> wb_ack_o)
    else $error("read data moved without ack");
  a_rdata_read: assert property ($changed(wb_dat_o) |-> $past(req && !wb_we_i))
    else $error("read data moved without a read");
  a_cal_by_cmd: assert property ($changed(rc_cal_o) |-> since_cmd_ff < 3'h7)
    else $error("calibration changed without a command");
  a_reset_zero: assert property (disable iff (1'b0)
    rst_i |=> !wb_ack_o && wb_dat_o == 32'h0 && rc_cal_o == 8'h0 && !debug_en_o)
    else $error("outputs not cleared by reset");
  c_read: cover property (req && !wb_we_i ##1 wb_ack_o);
  c_cal: cover property ($changed(rc_cal_o));
  c_debug_off: cover property ($fell(debug_en_o));
endmodule : fpf_core_asserts

bind fpf_core fpf_core_asserts u_asserts (.*);

// File: test/fpf_core_test.sv
/*
 Self-checking bench for fpf_core driven through the programmer model.
 Assumes short cycle counts 20/40/60 and the hand-over register map.
*/
`timescale 1ns/1ns
module fpf_core_test;
  logic        clk_i;
  logic        rst_i;
  logic        cyc, stb, we, ack, dbg;
  logic [7:0]  adr, cal;
  logic [3:0]  sel;
  logic [31:0] dw, dr, r, s;
  int          n_fail = 0;
  int          num_checks = 0;
  fpf_core #(.WR_CYC(20), .AWR_CYC(40), .ERS_CYC(60)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .rc_cal_o(cal), .debug_en_o(dbg));
  fpf_prog_model p (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(dr), .wb_cyc_o(cyc),
    .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dw));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic fw(input fpf_pkg::fpf_op_e op, input logic [1:0] sp, input logic [15:0] a, input logic [7:0] d);
    p.cmd(op, sp, a, d);
    p.wait_idle(s);
  endtask : fw
  task automatic t_defaults;
    p.wait_idle(s);
    chk(s[9:2], {2'h1, 2'h3, 2'h3, 1'b1, 1'b1});
    for (int i = 0; i < fpf_pkg::NUM_FUSES; i++) begin
      p.rd(2'h1, i[15:0], r);
      chk(r, 32'h1FF);
    end
    for (int i = 0; i < 2; i++) begin
      p.rd(2'h2, i[15:0], r);
      chk(r, 32'h1FF);
    end
    $display("test defaults done");
  endtask : t_defaults
  task automatic t_poll;
    p.cmd(fpf_pkg::FPF_OP_LOAD, 2'h0, 16'h003F, 8'h11);
    p.cmd(fpf_pkg::FPF_OP_LOAD, 2'h0, 16'h0005, 8'hA5);
    p.cmd(fpf_pkg::FPF_OP_WRITE, 2'h0, 16'h0005, 8'hA5);
    p.rd(2'h0, 16'h0005, r);
    chk(r[7:0], 8'h25);
    p.wait_idle(s);
    fw(fpf_pkg::FPF_OP_WRITE, 2'h1, 16'h0005, 8'h00);
    p.rd(2'h1, 16'h0005, r);
    chk(r, 32'h100);
    fw(fpf_pkg::FPF_OP_WRITE, 2'h1, 16'h0005, 8'hFF);
    p.rd(2'h1, 16'h0005, r);
    chk(r, 32'h100);
    fw(fpf_pkg::FPF_OP_WRITE_AE, 2'h1, 16'h0005, 8'hFF);
    p.rd(2'h1, 16'h0005, r);
    chk(r, 32'h1FF);
    $display("test poll and fuse done");
  endtask : t_poll
  task automatic t_apply;
    fw(fpf_pkg::FPF_OP_WRITE, 2'h1, {12'h0, fpf_pkg::FUSE_RST_EN}, 8'h00);
    fw(fpf_pkg::FPF_OP_WRITE, 2'h1, {12'h0, fpf_pkg::FUSE_CS0}, 8'h00);
    chk(s[7:3], {fpf_pkg::FPF_CLK_RC, 2'h3, 1'b1});
    fw(fpf_pkg::FPF_OP_SESSION_END, 2'h0, 16'h0, 8'h00);
    chk(s[7:3], {fpf_pkg::FPF_CLK_RC, 2'h3, 1'b0});
    $display("test fuse apply done");
  endtask : t_apply
  task automatic t_sig;
    fw(fpf_pkg::FPF_OP_WRITE, 2'h1, {12'h0, fpf_pkg::FUSE_APPPROG_EN}, 8'h00);
    fw(fpf_pkg::FPF_OP_SESSION_END, 2'h0, 16'h0, 8'h00);
    fw(fpf_pkg::FPF_OP_APP_WRITE, 2'h3, 16'h0080, 8'hC3);
    fw(fpf_pkg::FPF_OP_APP_WRITE, 2'h3, 16'h00C0, 8'h5A);
    p.rd(2'h3, 16'h0000, r);
    chk(r, 32'h1C3);
    fw(fpf_pkg::FPF_OP_WRITE, 2'h3, 16'h0000, 8'h11);
    p.rd(2'h3, 16'h0000, r);
    chk(r, 32'h1C3);
    fw(fpf_pkg::FPF_OP_WRITE, 2'h1, {12'h0, fpf_pkg::FUSE_SIG_PROG}, 8'h00);
    fw(fpf_pkg::FPF_OP_WRITE, 2'h3, 16'h0000, 8'h11);
    p.rd(2'h3, 16'h0000, r);
    chk(r, 32'h111);
    fw(fpf_pkg::FPF_OP_POR, 2'h0, 16'h0, 8'h00);
    chk(cal, 8'h5A);
    chk(s[7:6], fpf_pkg::FPF_CLK_SLOW_CRYSTAL);
    p.cmd(fpf_pkg::FPF_OP_CHIP_ERASE, 2'h0, 16'h0, 8'h00);
    p.rd(2'h0, 16'h0005, r);
    chk(r[7:0], 8'h7F);
    p.wait_idle(s);
    p.rd(2'h3, 16'h0000, r);
    chk(r, 32'h1FF);
    p.rd(2'h3, 16'h0040, r);
    chk(r, 32'h15A);
    $display("test signature done");
  endtask : t_sig
  task automatic t_lock;
    fw(fpf_pkg::FPF_OP_WRITE, 2'h2, 16'h0000, 8'h00);
    chk(s[9:8], 2'h2);
    fw(fpf_pkg::FPF_OP_WRITE, 2'h1, 16'h0009, 8'h00);
    p.rd(2'h1, 16'h0009, r);
    chk(r, 32'h1FF);
    fw(fpf_pkg::FPF_OP_WRITE, 2'h3, 16'h0001, 8'h22);
    p.rd(2'h3, 16'h0001, r);
    chk(r[7:0], 8'hFF);
    fw(fpf_pkg::FPF_OP_CHIP_ERASE, 2'h0, 16'h0, 8'h00);
    chk(s[9:8], 2'h1);
    fw(fpf_pkg::FPF_OP_WRITE, 2'h1, {12'h0, fpf_pkg::FUSE_DEBUG_EN}, 8'h00);
    chk(dbg, 1'b1);
    fw(fpf_pkg::FPF_OP_WRITE, 2'h2, 16'h0001, 8'h00);
    fw(fpf_pkg::FPF_OP_WRITE, 2'h2, 16'h0000, 8'h00);
    chk(s[9:8], 2'h3);
    chk(dbg, 1'b0);
    p.rd(2'h0, 16'h0005, r);
    chk(r[8], 1'b0);
    p.rd(2'h3, 16'h0040, r);
    chk(r, 32'h15A);
    $display("test locks done");
  endtask : t_lock
  initial begin
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_defaults();
    t_poll();
    t_apply();
    t_sig();
    t_lock();
    end_sim();
  end
  // about 1k cycles expected; twenty times that is a hang
  initial begin
    #(20000 * 8);
    n_fail++;
    end_sim();
  end
endmodule : fpf_core_test

// File: test/fpf_prog_model.sv
/*
 External programmer model: classic Wishbone master plus command helpers.
 Assumes the slave acks each request; spaces 0 code,1 fuse,2 lock,3 sig.
*/
`timescale 1ns/1ns
module fpf_prog_model (
  input  wire logic        clk_i,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic      [7:0]  wb_adr_o,
  output logic      [3:0]  wb_sel_o,
  output logic      [31:0] wb_dat_o
);
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'hF;
    wb_dat_o = 32'h0;
  end
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_adr_o <= a;
    wb_dat_o <= d;
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
  endtask : xfer
  task automatic cmd(input fpf_pkg::fpf_op_e op, input logic [1:0] sp, input logic [15:0] a, input logic [7:0] d);
    logic [31:0] q;
    // fuse and lock bytes are only ever all zeros or all ones
    if (sp inside {2'h1, 2'h2} && !(d inside {8'h00, 8'hFF})) return;
    xfer(1'b1, fpf_pkg::REG_ADDR, {16'h0, a}, q);
    xfer(1'b1, fpf_pkg::REG_DATA, {24'h0, d}, q);
    xfer(1'b1, fpf_pkg::REG_CMD, {26'h0, sp, op}, q);
  endtask : cmd
  task automatic rd(input logic [1:0] sp, input logic [15:0] a, output logic [31:0] r);
    cmd(fpf_pkg::FPF_OP_READ, sp, a, 8'h00);
    xfer(1'b0, fpf_pkg::REG_RDATA, 32'h0, r);
    r = {23'h0, r[8:0]};
  endtask : rd
  task automatic wait_idle(output logic [31:0] s);
    do xfer(1'b0, fpf_pkg::REG_STATUS, 32'h0, s); while (s[0] !== 1'b0);
  endtask : wait_idle
endmodule : fpf_prog_model
